//--- design/qdr_defs.svh
/*
  Frame field positions, command codes and reset values for the quad DAC
  register decode. Assumes a 24-bit frame with the read flag in the top bit.
*/
`ifndef QDR_DEFS_SVH
`define QDR_DEFS_SVH

// frame layout
`define QDR_FRAME_W     24
`define QDR_DATA_W      16
`define QDR_RW_BIT      23
`define QDR_REG_MSB     21
`define QDR_REG_LSB     19
`define QDR_CH_MSB      18
`define QDR_CH_LSB      16

// register select codes
`define QDR_REG_FUNC    3'h0
`define QDR_REG_DATA    3'h2
`define QDR_REG_RANGE   3'h3
`define QDR_REG_GAIN    3'h4
`define QDR_REG_OFFSET  3'h5

// function commands carried in channel select
`define QDR_FN_NOP      3'h0
`define QDR_FN_CTRL     3'h1
`define QDR_FN_CLEAR    3'h4
`define QDR_FN_LOAD     3'h5
`define QDR_CH_ALL      3'h4

// control word bit positions
`define QDR_CTRL_GND    5
`define QDR_CTRL_D1DIR  4
`define QDR_CTRL_D1VAL  3
`define QDR_CTRL_D0DIR  2
`define QDR_CTRL_D0VAL  1
`define QDR_CTRL_SDODIS 0
`define QDR_CTRL_W      6

// per-channel field widths
`define QDR_RANGE_W     2
`define QDR_GAIN_W      6
`define QDR_OFFSET_W    8
`define QDR_SHIFT_W     7
`define QDR_RANGE_RSVD  2'h3

// reset and clear values
`define QDR_CODE_RST    16'h0000
`define QDR_CLEAR_CODE  16'h0000
`define QDR_RANGE_RST   2'h0
`define QDR_GAIN_RST    6'h00
`define QDR_OFFSET_RST  8'h00
`define QDR_SHIFT_RST   7'h00
`define QDR_BIT_RST     1'h0
`define QDR_WORD_ZERO   16'h0000

`endif

//--- design/qdr_pkg.sv
/*
  Types for the quad DAC register decode.
  Assumes qdr_defs.svh is on the include path.
*/
`include "qdr_defs.svh"

package qdr_pkg;

    typedef enum logic [2:0]
    {
        QDR_SEL_FUNC   = `QDR_REG_FUNC,
        QDR_SEL_DATA   = `QDR_REG_DATA,
        QDR_SEL_RANGE  = `QDR_REG_RANGE,
        QDR_SEL_GAIN   = `QDR_REG_GAIN,
        QDR_SEL_OFFSET = `QDR_REG_OFFSET
    } qdr_reg_type;

endpackage : qdr_pkg

//--- design/qdr_channel.sv
/*
  One DAC channel's register set: stored code, active code, range,
  fine gain trim and offset trim, plus the full-scale shifts the gain
  trim implies. Assumes the decoder gives one-cycle write, load, clear.
*/
`timescale 1ns/100ps
`include "qdr_defs.svh"

module qdr_channel
    import qdr_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // write strobe and data
    input  wire logic                     wr_en,
    input  wire logic [2:0]               wr_sel,
    input  wire logic [`QDR_DATA_W-1:0]   wr_data,
    input  wire logic                     load,
    input  wire logic                     clear,
    // register contents
    output logic      [`QDR_DATA_W-1:0]   in_code,
    output logic      [`QDR_DATA_W-1:0]   active_code,
    output logic      [`QDR_RANGE_W-1:0]  range_code,
    output logic      [`QDR_GAIN_W-1:0]   gain_trim,
    output logic      [`QDR_OFFSET_W-1:0] offset_trim,
    output logic      [`QDR_SHIFT_W-1:0]  pos_fs_shift,
    output logic      [`QDR_SHIFT_W-1:0]  neg_fs_shift
);

    logic [`QDR_DATA_W-1:0]   next_in_code;
    logic [`QDR_DATA_W-1:0]   next_active_code;
    logic [`QDR_RANGE_W-1:0]  next_range_code;
    logic [`QDR_GAIN_W-1:0]   next_gain_trim;
    logic [`QDR_OFFSET_W-1:0] next_offset_trim;
    logic [`QDR_SHIFT_W-1:0]  next_pos_fs_shift;
    logic [`QDR_SHIFT_W-1:0]  next_neg_fs_shift;

    always_comb
    begin
        next_in_code     = in_code;
        next_active_code = active_code;
        next_range_code  = range_code;
        next_gain_trim   = gain_trim;
        next_offset_trim = offset_trim;
        if (wr_en)
        begin
            unique case (wr_sel)
                `QDR_REG_DATA:   next_in_code = wr_data;
                `QDR_REG_RANGE:
                    // code 11 has no range, so it is dropped
                    if (wr_data[`QDR_RANGE_W-1:0] != `QDR_RANGE_RSVD)
                        next_range_code = wr_data[`QDR_RANGE_W-1:0];
                `QDR_REG_GAIN:   next_gain_trim = wr_data[`QDR_GAIN_W-1:0];
                `QDR_REG_OFFSET: next_offset_trim = wr_data[`QDR_OFFSET_W-1:0];
                default:         next_in_code = in_code;
            endcase
        end
        // zero code is 0 V in twos complement and -FS in offset binary
        if (clear)
            next_active_code = `QDR_CLEAR_CODE;
        else if (load)
            next_active_code = in_code;
        // half-step units: the two end points move apart or together
        next_pos_fs_shift = {next_gain_trim[`QDR_GAIN_W-1], next_gain_trim};
        next_neg_fs_shift = `QDR_SHIFT_RST - {next_gain_trim[`QDR_GAIN_W-1], next_gain_trim};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_code      <= `QDR_CODE_RST;
            active_code  <= `QDR_CODE_RST;
            range_code   <= `QDR_RANGE_RST;
            gain_trim    <= `QDR_GAIN_RST;
            offset_trim  <= `QDR_OFFSET_RST;
            pos_fs_shift <= `QDR_SHIFT_RST;
            neg_fs_shift <= `QDR_SHIFT_RST;
        end
        else
        begin
            in_code      <= next_in_code;
            active_code  <= next_active_code;
            range_code   <= next_range_code;
            gain_trim    <= next_gain_trim;
            offset_trim  <= next_offset_trim;
            pos_fs_shift <= next_pos_fs_shift;
            neg_fs_shift <= next_neg_fs_shift;
        end
    end

endmodule : qdr_channel

//--- design/qdr_decode.sv
/*
  Register decode for a quad 16-bit bipolar DAC: routes 24-bit frames to
  the function register and the four channel register sets, and answers
  read frames. Assumes a frame deserialiser on the same clock presents
  whole frames with a one-cycle strobe; aux pins arrive unsynchronised.
*/
// Notes on behaviour
// - register select 000 makes the frame a function command chosen by channel select
// - function 000 is a no-op changing nothing; host sends it as readback filler
// - control bit 5 enables local ground offset adjust; disabled after reset
// - control bits 4 and 2 set aux pin 1 and 0 direction; input by default
// - bits 3 and 1 drive aux pins when outputs; inputs read back pin level
// - control bit 0 disables serial data output; bits 15 to 6 are ignored
// - function 100 clears all channel outputs to zero code; data ignored
// - function 101 loads stored codes into active registers; data ignored
// - register select 010 stores the 16-bit output code of the selected channel
// - register select 011 writes the 2-bit range code from bits 1 and 0
// - register select 100 writes a 6-bit twos complement gain trim
// - each gain step moves both full-scale points half a step, opposite sense
// - register select 101 writes an 8-bit twos complement offset trim
// - channel select picks one of four channel sets or all of them
// - read flag chooses between writing a register and reading it back
// - register select and channel select together choose the target register
`timescale 1ns/100ps
`include "qdr_defs.svh"

module qdr_decode
    import qdr_pkg::*;
#(
    parameter int NUM_CH = 4
)
(
    // clock and reset
    input  wire logic                             clk,
    input  wire logic                             rst_n,
    // frame from the deserialiser
    input  wire logic                             frame_valid,
    input  wire logic [`QDR_FRAME_W-1:0]          frame_word,
    // readback toward the serial output
    output logic                                  rd_valid,
    output logic      [`QDR_DATA_W-1:0]           rd_word,
    output logic                                  sdo_enable,
    // auxiliary pins
    input  wire logic [1:0]                       aux_pin_in,
    output logic      [1:0]                       aux_pin_out,
    output logic      [1:0]                       aux_pin_oe_n,
    // analog control
    output logic                                  gnd_adjust_en,
    output logic      [NUM_CH*`QDR_DATA_W-1:0]    active_code,
    output logic      [NUM_CH*`QDR_RANGE_W-1:0]   range_code,
    output logic      [NUM_CH*`QDR_GAIN_W-1:0]    gain_trim,
    output logic      [NUM_CH*`QDR_OFFSET_W-1:0]  offset_trim,
    output logic      [NUM_CH*`QDR_SHIFT_W-1:0]   pos_fs_shift,
    output logic      [NUM_CH*`QDR_SHIFT_W-1:0]   neg_fs_shift
);

    logic                    is_read;
    logic                    is_write;
    qdr_reg_type             reg_sel;
    logic [2:0]              ch_sel;
    logic [`QDR_DATA_W-1:0]  data;
    logic                    is_func;
    logic                    is_chan_reg;
    logic                    ch_single;
    logic [1:0]              ch_idx;
    logic                    fn_ctrl;
    logic                    fn_clear;
    logic                    fn_load;
    logic [NUM_CH-1:0]       ch_wr;
    logic [`QDR_DATA_W-1:0]  in_code [NUM_CH];
    logic [1:0]              aux_meta;
    logic [1:0]              aux_sync;
    logic [1:0]              aux_dir;
    logic [1:0]              aux_level;
    logic                    sdo_disable;
    logic [1:0]              next_aux_dir;
    logic [1:0]              next_aux_pin_out;
    logic                    next_gnd_adjust_en;
    logic                    next_sdo_disable;
    logic                    next_rd_valid;
    logic [`QDR_DATA_W-1:0]  next_rd_word;

    // frame fields
    always_comb
    begin
        is_read     = frame_valid && frame_word[`QDR_RW_BIT];
        is_write    = frame_valid && !frame_word[`QDR_RW_BIT];
        reg_sel     = qdr_reg_type'(frame_word[`QDR_REG_MSB:`QDR_REG_LSB]);
        ch_sel      = frame_word[`QDR_CH_MSB:`QDR_CH_LSB];
        data        = frame_word[`QDR_DATA_W-1:0];
        is_func     = reg_sel == QDR_SEL_FUNC;
        is_chan_reg = reg_sel == QDR_SEL_DATA || reg_sel == QDR_SEL_RANGE
                      || reg_sel == QDR_SEL_GAIN || reg_sel == QDR_SEL_OFFSET;
        ch_single   = ch_sel < `QDR_CH_ALL;
        ch_idx      = ch_sel[1:0];
        // nop and unlisted codes fall through with no strobe
        fn_ctrl     = is_write && is_func && ch_sel == `QDR_FN_CTRL;
        fn_clear    = is_write && is_func && ch_sel == `QDR_FN_CLEAR;
        fn_load     = is_write && is_func && ch_sel == `QDR_FN_LOAD;
    end

    // channel strobes: one channel or broadcast, 101-111 hit nothing
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            ch_wr[i] = is_write && is_chan_reg
                       && ((ch_single && ch_idx == i[1:0]) || ch_sel == `QDR_CH_ALL);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : gen_ch
            qdr_channel u_ch
            (
                .clk          (clk),
                .rst_n        (rst_n),
                .wr_en        (ch_wr[g]),
                .wr_sel       (reg_sel),
                .wr_data      (data),
                .load         (fn_load),
                .clear        (fn_clear),
                .in_code      (in_code[g]),
                .active_code  (active_code[g*`QDR_DATA_W +: `QDR_DATA_W]),
                .range_code   (range_code[g*`QDR_RANGE_W +: `QDR_RANGE_W]),
                .gain_trim    (gain_trim[g*`QDR_GAIN_W +: `QDR_GAIN_W]),
                .offset_trim  (offset_trim[g*`QDR_OFFSET_W +: `QDR_OFFSET_W]),
                .pos_fs_shift (pos_fs_shift[g*`QDR_SHIFT_W +: `QDR_SHIFT_W]),
                .neg_fs_shift (neg_fs_shift[g*`QDR_SHIFT_W +: `QDR_SHIFT_W])
            );
        end
    endgenerate

    // pin synchroniser; only the second stage is looked at
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_meta <= 2'h0;
            aux_sync <= 2'h0;
        end
        else
        begin
            aux_meta <= aux_pin_in;
            aux_sync <= aux_meta;
        end
    end

    // readable value bit: driven value for outputs, pin for inputs
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            aux_level[i] = aux_dir[i] ? aux_pin_out[i] : aux_sync[i];
        end
    end

    // control word
    always_comb
    begin
        next_aux_dir       = aux_dir;
        next_aux_pin_out   = aux_pin_out;
        next_gnd_adjust_en = gnd_adjust_en;
        next_sdo_disable   = sdo_disable;
        if (fn_ctrl)
        begin
            // bits 15:6 carry nothing and are not looked at
            next_gnd_adjust_en = data[`QDR_CTRL_GND];
            next_aux_dir[1]    = data[`QDR_CTRL_D1DIR];
            next_aux_dir[0]    = data[`QDR_CTRL_D0DIR];
            next_sdo_disable   = data[`QDR_CTRL_SDODIS];
            // a value bit only counts where the same frame makes an output
            if (data[`QDR_CTRL_D1DIR])
                next_aux_pin_out[1] = data[`QDR_CTRL_D1VAL];
            if (data[`QDR_CTRL_D0DIR])
                next_aux_pin_out[0] = data[`QDR_CTRL_D0VAL];
        end
    end

    // readback word for the addressed register
    always_comb
    begin
        next_rd_valid = is_read;
        next_rd_word  = `QDR_WORD_ZERO;
        if (is_read && is_func && ch_sel == `QDR_FN_CTRL)
        begin
            next_rd_word[`QDR_CTRL_GND]    = gnd_adjust_en;
            next_rd_word[`QDR_CTRL_D1DIR]  = aux_dir[1];
            next_rd_word[`QDR_CTRL_D1VAL]  = aux_level[1];
            next_rd_word[`QDR_CTRL_D0DIR]  = aux_dir[0];
            next_rd_word[`QDR_CTRL_D0VAL]  = aux_level[0];
            next_rd_word[`QDR_CTRL_SDODIS] = sdo_disable;
        end
        else if (is_read && ch_single)
        begin
            // broadcast select has no single register to return
            unique case (reg_sel)
                QDR_SEL_DATA:
                    next_rd_word = in_code[ch_idx];
                QDR_SEL_RANGE:
                    next_rd_word[`QDR_RANGE_W-1:0] = range_code[ch_idx*`QDR_RANGE_W +: `QDR_RANGE_W];
                QDR_SEL_GAIN:
                    next_rd_word[`QDR_GAIN_W-1:0] = gain_trim[ch_idx*`QDR_GAIN_W +: `QDR_GAIN_W];
                QDR_SEL_OFFSET:
                    next_rd_word[`QDR_OFFSET_W-1:0] = offset_trim[ch_idx*`QDR_OFFSET_W +: `QDR_OFFSET_W];
                default:
                    next_rd_word = `QDR_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aux_dir       <= 2'h0;
            aux_pin_out   <= 2'h0;
            aux_pin_oe_n  <= 2'h3;
            gnd_adjust_en <= `QDR_BIT_RST;
            sdo_disable   <= `QDR_BIT_RST;
            sdo_enable    <= 1'h1;
            rd_valid      <= `QDR_BIT_RST;
            rd_word       <= `QDR_WORD_ZERO;
        end
        else
        begin
            aux_dir       <= next_aux_dir;
            aux_pin_out   <= next_aux_pin_out;
            aux_pin_oe_n  <= ~next_aux_dir;
            gnd_adjust_en <= next_gnd_adjust_en;
            sdo_disable   <= next_sdo_disable;
            sdo_enable    <= !next_sdo_disable;
            rd_valid      <= next_rd_valid;
            rd_word       <= next_rd_word;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence ctrl_frame_s;
        is_write && is_func && ch_sel == `QDR_FN_CTRL;
    endsequence

    sequence dead_func_s;
        is_write && is_func && ch_sel != `QDR_FN_CTRL
        && ch_sel != `QDR_FN_CLEAR && ch_sel != `QDR_FN_LOAD;
    endsequence

    sequence ch0_data_s;
        is_write && reg_sel == QDR_SEL_DATA && (ch_sel == 3'h0 || ch_sel == `QDR_CH_ALL);
    endsequence

    sequence load_s;
        is_write && is_func && ch_sel == `QDR_FN_LOAD;
    endsequence

    nop_keeps_state_a : assert property (
        dead_func_s |=> $stable(aux_dir) && $stable(gnd_adjust_en) && $stable(sdo_enable)
                        && $stable(active_code) && $stable(range_code))
        else $error("function no-op changed state");

    other_fn_idle_a : assert property (
        (is_write && is_func && ch_sel[2:1] == 2'h1) |=> $stable(in_code[0]) && $stable(gain_trim))
        else $error("undefined function code changed a register");

    gnd_adjust_set_a : assert property (
        ctrl_frame_s |=> gnd_adjust_en == $past(frame_word[`QDR_CTRL_GND]))
        else $error("ground offset adjust enable not taken");

    aux_dir_set_a : assert property (
        ctrl_frame_s |=> aux_pin_oe_n[1] == !$past(frame_word[`QDR_CTRL_D1DIR])
                         && aux_pin_oe_n[0] == !$past(frame_word[`QDR_CTRL_D0DIR]))
        else $error("aux direction not taken");

    aux_value_drive_a : assert property (
        (ctrl_frame_s ##0 frame_word[`QDR_CTRL_D1DIR])
        |=> aux_pin_out[1] == $past(frame_word[`QDR_CTRL_D1VAL]))
        else $error("aux pin 1 value not driven");

    aux_input_hold_a : assert property (
        (ctrl_frame_s ##0 !frame_word[`QDR_CTRL_D0DIR]) |=> $stable(aux_pin_out[0]))
        else $error("write to input aux pin not ignored");

    sdo_disable_set_a : assert property (
        ctrl_frame_s |=> sdo_enable == !$past(frame_word[`QDR_CTRL_SDODIS]))
        else $error("serial output disable not taken");

    clear_zero_a : assert property (
        (is_write && is_func && ch_sel == `QDR_FN_CLEAR) |=> active_code == '0)
        else $error("software clear did not zero outputs");

    data_then_load_a : assert property (
        (ch0_data_s ##1 !frame_valid ##1 load_s)
        |=> active_code[`QDR_DATA_W-1:0] == $past(frame_word[`QDR_DATA_W-1:0], 3))
        else $error("loaded code differs from stored code");

    data_store_a : assert property (
        ch0_data_s |=> in_code[0] == $past(data))
        else $error("channel code not stored");

    range_rsvd_a : assert property (
        (is_write && reg_sel == QDR_SEL_RANGE && data[`QDR_RANGE_W-1:0] == `QDR_RANGE_RSVD)
        |=> $stable(range_code))
        else $error("reserved range code accepted");

    gain_span_a : assert property (
        1'b1 |-> pos_fs_shift[`QDR_SHIFT_W-1:0] + neg_fs_shift[`QDR_SHIFT_W-1:0] == 7'h00
                 && pos_fs_shift[`QDR_GAIN_W-1:0] == gain_trim[`QDR_GAIN_W-1:0])
        else $error("full-scale shifts not opposite halves of gain trim");

    offset_store_a : assert property (
        (is_write && reg_sel == QDR_SEL_OFFSET && ch_sel == `QDR_CH_ALL)
        |=> offset_trim[`QDR_OFFSET_W-1:0] == $past(data[`QDR_OFFSET_W-1:0])
            && offset_trim[NUM_CH*`QDR_OFFSET_W-1 -: `QDR_OFFSET_W] == $past(data[`QDR_OFFSET_W-1:0]))
        else $error("broadcast offset write missed a channel");

    readback_a : assert property (
        is_read |=> rd_valid ##1 !rd_valid || $past(is_read))
        else $error("read frame answer not one cycle later");

endmodule : qdr_decode

//--- testbench/qdr_host_model.sv
/*
  Host model for the quad DAC register decode: presents whole frames with
  a one-cycle strobe and drives the far end of the two aux pins.
  Assumes one shared clock and calls of send from a single process.
*/
`timescale 1ns/100ps
`include "qdr_defs.svh"

module qdr_host_model
(
    // clock
    input  wire logic                      clk,
    // frame port
    output logic                           frame_valid,
    output logic      [`QDR_FRAME_W-1:0]   frame_word,
    // readback
    input  wire logic                      rd_valid,
    input  wire logic [`QDR_DATA_W-1:0]    rd_word,
    // aux pins
    input  wire logic [1:0]                aux_pin_out,
    input  wire logic [1:0]                aux_pin_oe_n,
    output logic      [1:0]                aux_pin_in
);
    logic [1:0]             aux_ext;
    logic                   last_valid;
    logic [`QDR_DATA_W-1:0] last_rd;

    initial
    begin
        frame_valid = 1'h0;
        frame_word  = 24'h000000;
        aux_ext     = 2'h0;
        last_valid  = 1'h0;
        last_rd     = 16'h0000;
    end

    // device wins the wire where it drives, else the host level shows
    assign aux_pin_in = (~aux_pin_oe_n & aux_pin_out) | (aux_pin_oe_n & aux_ext);

    // word is scrambled once the strobe drops, so stale data never looks valid
    task automatic send(input logic [`QDR_FRAME_W-1:0] w);
        @(posedge clk);
        frame_word  <= w;
        frame_valid <= 1'h1;
        @(posedge clk);
        frame_valid <= 1'h0;
        frame_word  <= ~w;
        #1;
        last_valid = rd_valid;
        last_rd    = rd_word;
    endtask : send
endmodule : qdr_host_model

//--- testbench/quad_dac_register_decode_test.sv
/*
  Self-checking bench for the quad DAC register decode.
  Assumes the host model drives frames and aux pins; one 100 MHz clock.
*/
`timescale 1ns/100ps
`include "qdr_defs.svh"

module quad_dac_register_decode_test;
    logic        clk;
    logic        rst_n;
    logic        frame_valid;
    logic [23:0] frame_word;
    logic        rd_valid;
    logic [15:0] rd_word;
    logic        sdo_enable;
    logic [1:0]  aux_pin_in;
    logic [1:0]  aux_pin_out;
    logic [1:0]  aux_pin_oe_n;
    logic        gnd_adjust_en;
    logic [63:0] active_code;
    logic [7:0]  range_code;
    logic [23:0] gain_trim;
    logic [31:0] offset_trim;
    logic [27:0] pos_fs_shift;
    logic [27:0] neg_fs_shift;
    int          fail_count;
    int          samples_checked;
    int          cycles;

    qdr_decode #(.NUM_CH(4)) u_qdr_decode
    (
        .clk           (clk),
        .rst_n         (rst_n),
        .frame_valid   (frame_valid),
        .frame_word    (frame_word),
        .rd_valid      (rd_valid),
        .rd_word       (rd_word),
        .sdo_enable    (sdo_enable),
        .aux_pin_in    (aux_pin_in),
        .aux_pin_out   (aux_pin_out),
        .aux_pin_oe_n  (aux_pin_oe_n),
        .gnd_adjust_en (gnd_adjust_en),
        .active_code   (active_code),
        .range_code    (range_code),
        .gain_trim     (gain_trim),
        .offset_trim   (offset_trim),
        .pos_fs_shift  (pos_fs_shift),
        .neg_fs_shift  (neg_fs_shift)
    );

    qdr_host_model u_qdr_host_model
    (
        .clk          (clk),
        .frame_valid  (frame_valid),
        .frame_word   (frame_word),
        .rd_valid     (rd_valid),
        .rd_word      (rd_word),
        .aux_pin_out  (aux_pin_out),
        .aux_pin_oe_n (aux_pin_oe_n),
        .aux_pin_in   (aux_pin_in)
    );

    always #5 clk = ~clk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic read_back(input logic [23:0] w, input logic [15:0] exp);
        u_qdr_host_model.send(w);
        check(u_qdr_host_model.last_valid, 1'h1);
        check(u_qdr_host_model.last_rd, exp);
    endtask : read_back

    task automatic test_done;
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    task automatic test_reset;
        check({gnd_adjust_en, aux_pin_oe_n, sdo_enable}, 4'h7);
        check({range_code, gain_trim, offset_trim}, 64'h0);
    endtask : test_reset

    task automatic test_control;
        u_qdr_host_model.send(24'h01FFFF);
        check({gnd_adjust_en, aux_pin_oe_n, aux_pin_out, sdo_enable}, 6'h26);
        read_back(24'h810000, 16'h003F);
        u_qdr_host_model.send(24'h01000A);
        check({aux_pin_oe_n, aux_pin_out, sdo_enable}, 5'h1F);
        @(posedge clk);
        u_qdr_host_model.aux_ext <= 2'h1;
        repeat (4) @(posedge clk);
        read_back(24'h810000, 16'h0002);
    endtask : test_control

    task automatic test_data_load;
        u_qdr_host_model.send(24'h11BEEF);
        check(active_code, 64'h0);
        read_back(24'h910000, 16'hBEEF);
        u_qdr_host_model.send(24'h05FFFF);
        check(active_code, 64'h00000000BEEF0000);
        u_qdr_host_model.send(24'h141234);
        u_qdr_host_model.send(24'h050000);
        check(active_code, {4{16'h1234}});
        u_qdr_host_model.send(24'h04FFFF);
        check(active_code, 64'h0);
        read_back(24'h920000, 16'h1234);
    endtask : test_data_load

    task automatic test_trims;
        for (int c = 0; c < 3; c++)
        begin
            u_qdr_host_model.send(24'h1BFFFC | 24'(c));
            check(range_code[7:6], c[1:0]);
        end
        u_qdr_host_model.send(24'h1B0003);
        check(range_code, 8'h80);
        u_qdr_host_model.send(24'h20FFE0);
        check({gain_trim[5:0], pos_fs_shift[6:0], neg_fs_shift[6:0]}, {6'h20, 7'h60, 7'h20});
        u_qdr_host_model.send(24'h24001F);
        check({pos_fs_shift, neg_fs_shift}, {{4{7'h1F}}, {4{7'h61}}});
        u_qdr_host_model.send(24'h2AFF80);
        check(offset_trim, 32'h00800000);
        read_back(24'hAA0000, 16'h0080);
        u_qdr_host_model.send(24'h2C0011);
        check(offset_trim, {4{8'h11}});
    endtask : test_trims

    task automatic test_nop;
        logic [2:0] fn[5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
        foreach (fn[i])
            u_qdr_host_model.send({5'h00, fn[i], 16'hFFFF});
        u_qdr_host_model.send(24'h08FFFF);
        u_qdr_host_model.send(24'h9BFFFF);
        check({range_code, gain_trim[5:0], gnd_adjust_en, sdo_enable}, {8'h80, 6'h1F, 2'h1});
        check(active_code, 64'h0);
    endtask : test_nop

    // ceiling well above the roughly 80 cycles the scenarios need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            test_done();
        end
    end

    initial
    begin
        clk             = 1'h0;
        rst_n           = 1'h0;
        fail_count      = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        test_reset();
        test_control();
        test_data_load();
        test_trims();
        test_nop();
        test_done();
    end
endmodule : quad_dac_register_decode_test
